// >>> design/pmrs_sync.sv
/*
 Two-stage synchroniser for a bundle of pin-side levels.
 Assumes each input is a slow level that may change at any time relative to clk.
*/
`timescale 1ns/10ps
module pmrs_sync #(
	parameter int             W       = 1,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pmrs_sync_regs_t;

	pmrs_sync_regs_t r_q;
	pmrs_sync_regs_t r_d;

	// The first stage feeds only the second stage.
	always_comb begin
		r_d.s1 = d_in;
		r_d.s2 = r_q.s1;
		if (rst) begin
			r_d.s1 = RST_VAL;
			r_d.s2 = RST_VAL;
		end
	end

	always_ff @(posedge clk) begin
		r_q <= r_d;
	end

	assign q_out = r_q.s2;
endmodule

// >>> design/pmrs_top.sv
/*
 Power mode and reset sequencer: global power mode state machine, resource
 enables from the active template, wakeup handling, reset source collection
 with a reset status record, watchdog, and boost mode and pulse control.
 Assumes firmware bits arrive on clk; pins and supply monitors are asynchronous.
*/
// How it works
// - Active mode: enables follow template bits.
// - Disabled resource loses clock and bias.
// - CPU self-off; next wakeup re-enables it.
// - Wakeup forces active mode and CPU on.
// - Device starts in active mode after boot.
// - Sleep exit waits 12 us first.
// - Hibernate retains state and holds pins.
// - Retention voltage loss in hibernate resets.
// - Hibernate exits only on pin interrupt or reset, 100us.
// - Peripheral, supply, pin, timebase wake; resets too.
// - Boost has active and standby modes.
// - Auto pulse on crystal edges while low.
// - Hibernate forces boost active; firmware chooses otherwise.
// - Boost frequency: 100k, 400k, 2M, 32k.
// - Low external reset pin resets device.
// - Unkicked watchdog resets the device.
// - Software command resets the device.
// - System reset clears processor, peripherals, registers.
// - Status records last reset; cleared by POR.
// - Supply fault resets; warning interrupt first.
// - Power-up reset at least 100 ns, stretched.
// - Stable supply hands over; oscillator starts after.
// - Precise low-voltage trip acts like power-up.
// - Retention monitor resets only in sleep/hibernate.
`timescale 1ns/10ps
module pmrs_top #(
	parameter int NUM_RES         = 8,
	parameter int WATCHDOG_CYCLES = 40000
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic [NUM_RES-1:0]         active_template,
	input  wire logic                       mode_wr,
	input  wire logic [1:0]                 mode_req,
	input  wire logic                       cpu_off_req,
	input  wire logic [pmrs_pkg::WK_NUM-1:0] wake_en,
	input  wire logic                       periph_irq,
	input  wire logic                       timebase_irq,
	input  wire logic                       pin_irq,
	input  wire logic                       external_reset_pin_n,
	input  wire logic                       initial_power_on_reset,
	input  wire logic                       supplies_ramping,
	input  wire logic                       vccd_stable,
	input  wire logic                       precise_low_voltage_reset,
	input  wire logic                       retention_low_voltage_reset,
	input  wire logic                       supply_fault,
	input  wire logic                       supply_warn,
	input  wire logic                       watchdog_timer_enable,
	input  wire logic                       watchdog_timer_kick,
	input  wire logic                       sw_reset_req,
	input  wire logic                       sw_reset_disable,
	input  wire logic                       boost_active_req,
	input  wire logic [1:0]                 boost_freq_sel,
	input  wire logic                       auto_pulse_mode,
	input  wire logic                       xtal_32k,
	input  wire logic                       boost_below_level,
	output logic      [1:0]                 global_mode,
	output logic      [NUM_RES-1:0]         res_clk_en,
	output logic      [NUM_RES-1:0]         res_bias_en,
	output logic                            cpu_en,
	output logic                            retain_hold,
	output logic                            sys_reset,
	output logic      [pmrs_pkg::ST_W-1:0]  reset_status,
	output logic                            powerup_monitor_en,
	output logic                            main_internal_oscillator_en,
	output logic                            boost_active,
	output logic      [1:0]                 boost_freq,
	output logic                            boost_pulse
);
	localparam int DOG_W = $clog2(WATCHDOG_CYCLES + 1);
	localparam logic [DOG_W-1:0] DOG_LOAD = DOG_W'(WATCHDOG_CYCLES - 1);
	localparam logic [DOG_W-1:0] DOG_ONE  = DOG_W'(1);

	typedef struct packed {
		pmrs_pkg::pmrs_state_t              state;
		logic                               cpu_off;
		logic [pmrs_pkg::RESUME_W-1:0]      cnt;
		logic [2:0]                         rcnt;
		logic                               dog_on;
		logic [DOG_W-1:0]                   dog_cnt;
		logic                               powerup_off;
		logic                               osc_on;
		logic [pmrs_pkg::ST_W-1:0]          status;
		logic [NUM_RES-1:0]                 en;
		logic                               xtal_prev;
		logic                               pulse;
		logic                               boost_act;
		logic [1:0]                         freq;
	} pmrs_regs_t;

	pmrs_regs_t                  q;
	pmrs_regs_t                  d;
	logic [pmrs_pkg::SI_NUM-1:0] s;
	logic [pmrs_pkg::WK_NUM-1:0] wake_vec;
	logic                        wake_any;
	logic                        powerup_src;
	logic                        precise_src;
	logic                        retain_src;
	logic                        pin_src;
	logic                        dog_src;
	logic                        sw_src;
	logic                        fault_src;
	logic                        any_src;
	logic                        low_power;

	pmrs_sync #(
		.W       (pmrs_pkg::SI_NUM),
		.RST_VAL (pmrs_pkg::SI_RST_VAL)
	) u_sync (
		.clk   (clk),
		.rst   (rst),
		.d_in  ({pin_irq, boost_below_level, xtal_32k, supply_warn, supply_fault,
			retention_low_voltage_reset, precise_low_voltage_reset, vccd_stable,
			supplies_ramping, initial_power_on_reset, external_reset_pin_n}),
		.q_out (s)
	);

	function automatic pmrs_pkg::pmrs_mode_t mode_of(input pmrs_pkg::pmrs_state_t st);
		unique case (st)
			pmrs_pkg::PMRS_S_ALT:        mode_of = pmrs_pkg::PMRS_MODE_ALT;
			pmrs_pkg::PMRS_S_SLEEP,
			pmrs_pkg::PMRS_S_SLEEP_WAKE: mode_of = pmrs_pkg::PMRS_MODE_SLEEP;
			pmrs_pkg::PMRS_S_HIB,
			pmrs_pkg::PMRS_S_HIB_WAKE:   mode_of = pmrs_pkg::PMRS_MODE_HIB;
			default:                     mode_of = pmrs_pkg::PMRS_MODE_ACTIVE;
		endcase
	endfunction

	// Sleep and hibernate disable every resource whatever the template says.
	function automatic logic [NUM_RES-1:0] enables(input pmrs_pkg::pmrs_state_t st,
		input logic cpu_off, input logic [NUM_RES-1:0] tmpl);
		logic [NUM_RES-1:0] e;
		e = '0;
		if (st == pmrs_pkg::PMRS_S_ACTIVE || st == pmrs_pkg::PMRS_S_ALT) begin
			e = tmpl;
			e[pmrs_pkg::CPU_BIT] = !cpu_off;
		end
		enables = e;
	endfunction

	assign wake_vec[pmrs_pkg::WK_PERIPH] = periph_irq;
	assign wake_vec[pmrs_pkg::WK_SUPPLY] = s[pmrs_pkg::SI_WARN];
	assign wake_vec[pmrs_pkg::WK_PIN]    = s[pmrs_pkg::SI_PIN_IRQ];
	assign wake_vec[pmrs_pkg::WK_TIME]   = timebase_irq;
	assign wake_any  = |(wake_vec & wake_en);
	assign low_power = q.state inside {pmrs_pkg::PMRS_S_SLEEP, pmrs_pkg::PMRS_S_SLEEP_WAKE,
		pmrs_pkg::PMRS_S_HIB, pmrs_pkg::PMRS_S_HIB_WAKE};

	// The rough monitor covers power-up until the digital supply settles, then the precise one takes over.
	assign powerup_src = !q.powerup_off && (s[pmrs_pkg::SI_POWERUP] || s[pmrs_pkg::SI_RAMP]);
	assign precise_src = q.powerup_off && s[pmrs_pkg::SI_PRECISE];
	assign retain_src  = low_power && s[pmrs_pkg::SI_RETAIN];
	assign pin_src     = !s[pmrs_pkg::SI_PIN_N];
	assign dog_src     = q.dog_on && q.dog_cnt == '0 && !watchdog_timer_kick;
	assign sw_src      = sw_reset_req && !sw_reset_disable;
	assign fault_src   = s[pmrs_pkg::SI_FAULT];
	assign any_src     = powerup_src | precise_src | retain_src | pin_src | dog_src | sw_src | fault_src;

	always_comb begin
		d = q;
		d.pulse = 1'b0;
		d.xtal_prev = s[pmrs_pkg::SI_XTAL];
		if (s[pmrs_pkg::SI_VCCD_OK]) begin
			d.powerup_off = 1'b1;
		end
		d.osc_on = q.powerup_off && !s[pmrs_pkg::SI_PRECISE] && q.state != pmrs_pkg::PMRS_S_RESET;
		if (q.dog_on && q.state != pmrs_pkg::PMRS_S_HIB) begin
			if (watchdog_timer_kick) begin
				d.dog_cnt = DOG_LOAD;
			end else if (q.dog_cnt != '0) begin
				d.dog_cnt = q.dog_cnt - DOG_ONE;
			end
		end
		// Once armed the watchdog can only be disarmed by a power-on reset.
		if (watchdog_timer_enable && !q.dog_on) begin
			d.dog_on = 1'b1;
			d.dog_cnt = DOG_LOAD;
		end
		if (s[pmrs_pkg::SI_WARN]) begin
			d.status = '0;
			d.status[pmrs_pkg::ST_WARN] = 1'b1;
		end
		unique case (q.state)
			pmrs_pkg::PMRS_S_RESET: begin
				if (q.rcnt != '0) begin
					d.rcnt = q.rcnt - pmrs_pkg::RCNT_ONE;
				end else begin
					d.state = pmrs_pkg::PMRS_S_ACTIVE;
				end
			end
			pmrs_pkg::PMRS_S_ACTIVE, pmrs_pkg::PMRS_S_ALT: begin
				if (cpu_off_req) begin
					d.cpu_off = 1'b1;
				end
				if (wake_any) begin
					d.cpu_off = 1'b0;
					d.state = pmrs_pkg::PMRS_S_ACTIVE;
				end else if (mode_wr && q.state == pmrs_pkg::PMRS_S_ACTIVE) begin
					unique case (pmrs_pkg::pmrs_mode_t'(mode_req))
						pmrs_pkg::PMRS_MODE_ALT:    d.state = pmrs_pkg::PMRS_S_ALT;
						pmrs_pkg::PMRS_MODE_SLEEP:  d.state = pmrs_pkg::PMRS_S_SLEEP;
						pmrs_pkg::PMRS_MODE_HIB:    d.state = pmrs_pkg::PMRS_S_HIB;
						pmrs_pkg::PMRS_MODE_ACTIVE: d.state = pmrs_pkg::PMRS_S_ACTIVE;
					endcase
				end
			end
			pmrs_pkg::PMRS_S_SLEEP: begin
				if (wake_any) begin
					d.state = pmrs_pkg::PMRS_S_SLEEP_WAKE;
					d.cnt = pmrs_pkg::SLEEP_RESUME_CYC - pmrs_pkg::RESUME_ONE;
				end
			end
			pmrs_pkg::PMRS_S_HIB: begin
				// Only a pin interrupt or a reset source can bring the part out of hibernate.
				if (s[pmrs_pkg::SI_PIN_IRQ]) begin
					d.state = pmrs_pkg::PMRS_S_HIB_WAKE;
					d.cnt = pmrs_pkg::HIB_RESUME_CYC - pmrs_pkg::RESUME_ONE;
				end
			end
			pmrs_pkg::PMRS_S_SLEEP_WAKE, pmrs_pkg::PMRS_S_HIB_WAKE: begin
				if (q.cnt != '0) begin
					d.cnt = q.cnt - pmrs_pkg::RESUME_ONE;
				end else begin
					d.state = pmrs_pkg::PMRS_S_ACTIVE;
					d.cpu_off = 1'b0;
				end
			end
			default: begin
				d.state = pmrs_pkg::PMRS_S_RESET;
			end
		endcase
		// Any reset source wins over every mode step and holds the device in reset.
		if (any_src) begin
			d.state = pmrs_pkg::PMRS_S_RESET;
			d.rcnt = pmrs_pkg::POR_MIN_CYC - pmrs_pkg::RCNT_ONE;
			d.cpu_off = 1'b0;
			d.cnt = '0;
			// Reloading here keeps an expired count from holding the part in reset for ever.
			d.dog_cnt = DOG_LOAD;
			d.status = '0;
			d.status[pmrs_pkg::ST_PRECISE] = precise_src;
			d.status[pmrs_pkg::ST_RETAIN] = retain_src;
			d.status[pmrs_pkg::ST_PIN] = pin_src;
			d.status[pmrs_pkg::ST_WATCHDOG] = dog_src;
			d.status[pmrs_pkg::ST_SW] = sw_src;
			d.status[pmrs_pkg::ST_SUPPLY] = fault_src;
			if (!precise_src && !retain_src && !pin_src && !dog_src && !sw_src && !fault_src) begin
				d.status[pmrs_pkg::ST_POWERUP] = 1'b0;
			end
			if (powerup_src) begin
				d.status = '0;
				d.dog_on = 1'b0;
				d.powerup_off = 1'b0;
			end
		end
		d.en = enables(d.state, d.cpu_off, active_template);
		// Hibernate needs the regulator running, so standby is not allowed there.
		d.boost_act = (mode_of(d.state) == pmrs_pkg::PMRS_MODE_HIB) ? 1'b1 : boost_active_req;
		d.freq = boost_freq_sel;
		if (auto_pulse_mode && (s[pmrs_pkg::SI_XTAL] != q.xtal_prev) && s[pmrs_pkg::SI_BELOW]) begin
			d.pulse = 1'b1;
		end
		if (rst) begin
			d = '0;
			d.state = pmrs_pkg::PMRS_S_RESET;
			d.rcnt = pmrs_pkg::POR_MIN_CYC - pmrs_pkg::RCNT_ONE;
			d.boost_act = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		q <= d;
	end

	assign global_mode                 = mode_of(q.state);
	assign res_clk_en                  = q.en;
	assign res_bias_en                 = q.en;
	assign cpu_en                      = q.en[pmrs_pkg::CPU_BIT];
	// Config, SRAM and pin levels are frozen by this hold for the whole hibernate stay.
	assign retain_hold                 = global_mode == pmrs_pkg::PMRS_MODE_HIB;
	assign sys_reset                   = q.state == pmrs_pkg::PMRS_S_RESET;
	assign reset_status                = q.status;
	assign powerup_monitor_en          = !q.powerup_off;
	assign main_internal_oscillator_en = q.osc_on;
	assign boost_active                = q.boost_act;
	assign boost_freq                  = q.freq;
	assign boost_pulse                 = q.pulse;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	por_min_a: assert property ($rose(sys_reset) |-> sys_reset [*4])
		else $error("reset pulse shorter than minimum");
	boot_active_a: assert property ($fell(sys_reset) |-> global_mode == pmrs_pkg::PMRS_MODE_ACTIVE)
		else $error("not active after reset");
	sleep_load_a: assert property (q.state == pmrs_pkg::PMRS_S_SLEEP && wake_any && !any_src
		|=> q.state == pmrs_pkg::PMRS_S_SLEEP_WAKE && q.cnt == 12'h1df)
		else $error("sleep resume wait not loaded");
	sleep_hold_a: assert property (q.state == pmrs_pkg::PMRS_S_SLEEP_WAKE && q.cnt != '0 && !any_src
		|=> q.state == pmrs_pkg::PMRS_S_SLEEP_WAKE)
		else $error("left sleep before resume wait");
	hib_stay_a: assert property (q.state == pmrs_pkg::PMRS_S_HIB && !s[pmrs_pkg::SI_PIN_IRQ] && !any_src
		|=> q.state == pmrs_pkg::PMRS_S_HIB)
		else $error("hibernate left without pin interrupt");
	hib_bound_a: assert property (q.state == pmrs_pkg::PMRS_S_HIB_WAKE |-> q.cnt < 12'hfa0)
		else $error("hibernate resume too long");
	wake_cpu_a: assert property (q.state == pmrs_pkg::PMRS_S_ALT && wake_any && !any_src
		|=> global_mode == pmrs_pkg::PMRS_MODE_ACTIVE && cpu_en)
		else $error("wakeup did not restore active and cpu");
	retain_gate_a: assert property (q.state == pmrs_pkg::PMRS_S_ACTIVE && !powerup_src && !precise_src && !pin_src
		&& !dog_src && !sw_src && !fault_src |=> !sys_reset)
		else $error("retention monitor reset outside low power");
	boost_hib_a: assert property (retain_hold |-> boost_active)
		else $error("boost standby in hibernate");
	pulse_cause_a: assert property (boost_pulse |-> $past(auto_pulse_mode) && $past(s[pmrs_pkg::SI_BELOW]))
		else $error("boost pulse without cause");
	status_clr_a: assert property (powerup_src |=> reset_status == '0 && sys_reset)
		else $error("power-on reset did not clear status");
	osc_start_a: assert property (main_internal_oscillator_en |-> !powerup_monitor_en)
		else $error("oscillator ran before handover");
	sw_reset_a: assert property (sw_reset_req && !sw_reset_disable |=> sys_reset && reset_status[pmrs_pkg::ST_SW])
		else $error("software reset missed");
	alt_hold_a: assert property (q.state == pmrs_pkg::PMRS_S_ALT && !wake_any && !any_src
		|=> q.state == pmrs_pkg::PMRS_S_ALT)
		else $error("alternate active left without wakeup");
	warn_status_a: assert property (s[pmrs_pkg::SI_WARN] && !any_src |=> reset_status[pmrs_pkg::ST_WARN])
		else $error("supply warning not recorded");
	pin_reset_a: assert property (!s[pmrs_pkg::SI_PIN_N] |=> sys_reset)
		else $error("reset pin low without reset");

	sleep_wake_c: cover property (q.state == pmrs_pkg::PMRS_S_SLEEP_WAKE ##1 q.state == pmrs_pkg::PMRS_S_ACTIVE);
	hib_wake_c: cover property (q.state == pmrs_pkg::PMRS_S_HIB_WAKE ##1 q.state == pmrs_pkg::PMRS_S_ACTIVE);
	dog_reset_c: cover property (dog_src);
	alt_wake_c: cover property (q.state == pmrs_pkg::PMRS_S_ALT ##1 q.state == pmrs_pkg::PMRS_S_ACTIVE);
	pulse_c: cover property (boost_pulse);
endmodule

// >>> shared/pmrs_pkg.sv
/*
 Constants, codes and timing counts for the power mode and reset sequencer.
 Assumes a single 40 MHz system clock.
*/
package pmrs_pkg;
	localparam int CLK_HZ        = 40000000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int CYC_PER_US    = CLK_HZ / 1000000;

	// Least time: the sleep resume wait must not be cut short.
	localparam int SLEEP_RESUME_US = 12;
	// Longest time: hibernate resume must finish inside this bound, so round down.
	localparam int HIB_RESUME_US   = 100;
	// Least width of the power-up reset pulse.
	localparam int POR_MIN_NS      = 100;

	localparam int RESUME_W = 12;
	localparam logic [RESUME_W-1:0] SLEEP_RESUME_CYC = RESUME_W'(SLEEP_RESUME_US * CYC_PER_US);
	localparam logic [RESUME_W-1:0] HIB_RESUME_CYC   = RESUME_W'(HIB_RESUME_US * CYC_PER_US);
	localparam logic [RESUME_W-1:0] RESUME_ONE       = 12'h001;
	localparam logic [2:0]          POR_MIN_CYC      = 3'((POR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0]          RCNT_ONE         = 3'h1;

	typedef enum logic [1:0] {
		PMRS_MODE_ACTIVE = 2'h0,
		PMRS_MODE_ALT    = 2'h1,
		PMRS_MODE_SLEEP  = 2'h2,
		PMRS_MODE_HIB    = 2'h3
	} pmrs_mode_t;

	typedef enum logic [1:0] {
		PMRS_FREQ_100K = 2'h0,
		PMRS_FREQ_400K = 2'h1,
		PMRS_FREQ_2M   = 2'h2,
		PMRS_FREQ_32K  = 2'h3
	} pmrs_freq_t;

	typedef enum logic [2:0] {
		PMRS_S_RESET      = 3'h0,
		PMRS_S_ACTIVE     = 3'h1,
		PMRS_S_ALT        = 3'h2,
		PMRS_S_SLEEP      = 3'h3,
		PMRS_S_SLEEP_WAKE = 3'h4,
		PMRS_S_HIB        = 3'h5,
		PMRS_S_HIB_WAKE   = 3'h6
	} pmrs_state_t;

	// Reset status bit positions.
	localparam int ST_POWERUP  = 0;
	localparam int ST_PRECISE  = 1;
	localparam int ST_RETAIN   = 2;
	localparam int ST_PIN      = 3;
	localparam int ST_WATCHDOG = 4;
	localparam int ST_SW       = 5;
	localparam int ST_SUPPLY   = 6;
	localparam int ST_WARN     = 7;
	localparam int ST_W        = 8;

	// Positions of the pin-side inputs in the synchroniser bundle.
	localparam int SI_PIN_N   = 0;
	localparam int SI_POWERUP = 1;
	localparam int SI_RAMP    = 2;
	localparam int SI_VCCD_OK = 3;
	localparam int SI_PRECISE = 4;
	localparam int SI_RETAIN  = 5;
	localparam int SI_FAULT   = 6;
	localparam int SI_WARN    = 7;
	localparam int SI_XTAL    = 8;
	localparam int SI_BELOW   = 9;
	localparam int SI_PIN_IRQ = 10;
	localparam int SI_NUM     = 11;
	localparam logic [SI_NUM-1:0] SI_RST_VAL = 11'h001;

	// Wake source positions.
	localparam int WK_PERIPH = 0;
	localparam int WK_SUPPLY = 1;
	localparam int WK_PIN    = 2;
	localparam int WK_TIME   = 3;
	localparam int WK_NUM    = 4;

	localparam int CPU_BIT = 0;
endpackage

// >>> tb/pmrs_far_side.sv
/*
 Model of the sequencer's far side: the external reset pin with its pull-up and the 32 kHz crystal.
 Assumes the bench commands pin pulls and crystal run on its own clock.
*/
`timescale 1ns/10ps
module pmrs_far_side #(
	parameter int HALF = 8
) (
	input  wire logic clk,
	input  wire logic pin_low_cmd,
	input  wire logic xtal_run,
	output logic      external_reset_pin_n,
	output logic      xtal_32k
);
	int   cnt_q  = 0;
	logic xtal_q = 1'b0;

	// The pin has a pull-up, so it reads high whenever nobody pulls it down.
	assign external_reset_pin_n = !pin_low_cmd;
	assign xtal_32k = xtal_q;

	// The crystal edges are skewed off the clock edge, since the real crystal is unrelated in phase.
	always @(posedge clk) begin
		if (xtal_run) begin
			cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
			if (cnt_q == HALF - 1) begin
				xtal_q <= #3 ~xtal_q;
			end
		end
	end
endmodule

// >>> tb/tb_pmrs_top.sv
/*
 Self-checking bench for the power mode and reset sequencer.
 Assumes the far-side model and a watchdog period shortened to 20 cycles.
*/
`timescale 1ns/10ps
module tb_pmrs_top;
	logic                          clk = 1'b0;
	logic                          rst = 1'b1;
	logic [7:0]                    tmpl = 8'h3c;
	logic                          mode_wr = 1'b0;
	logic [1:0]                    mode_req = 2'h0;
	logic                          cpu_off = 1'b0;
	logic [pmrs_pkg::WK_NUM-1:0]   wake_en = 4'hf;
	logic                          p_irq = 1'b0, t_irq = 1'b0, pin_irq = 1'b0, xtal_run = 1'b0;
	logic                          pwr_trip = 1'b0, ramp = 1'b0, vccd_ok = 1'b0, warn = 1'b0;
	logic                          wd_en = 1'b0, wd_kick = 1'b0, sw_dis = 1'b0;
	logic                          boost_req = 1'b1, auto_pm = 1'b0, below = 1'b0;
	logic [1:0]                    fsel = 2'h0;
	logic [4:0]                    src = 5'h00;
	logic                          ext_n, xtal, cpu_en, retain, sys_rst, mon_en, osc_en, b_act, b_pulse;
	logic [1:0]                    gm, b_freq;
	logic [7:0]                    clk_en, bias_en, status;
	int                            miscompares = 0;
	int                            cmp_count = 0;

	always #12.5 clk = ~clk;

	pmrs_far_side u_pmrs_far_side (.clk(clk), .pin_low_cmd(src[4]), .xtal_run(xtal_run),
		.external_reset_pin_n(ext_n), .xtal_32k(xtal));

	pmrs_top #(.NUM_RES(8), .WATCHDOG_CYCLES(20)) u_pmrs_top (.clk(clk), .rst(rst), .active_template(tmpl),
		.mode_wr(mode_wr), .mode_req(mode_req), .cpu_off_req(cpu_off), .wake_en(wake_en), .periph_irq(p_irq),
		.timebase_irq(t_irq), .pin_irq(pin_irq), .external_reset_pin_n(ext_n), .initial_power_on_reset(pwr_trip),
		.supplies_ramping(ramp), .vccd_stable(vccd_ok), .precise_low_voltage_reset(src[0]),
		.retention_low_voltage_reset(src[1]), .supply_fault(src[2]), .supply_warn(warn),
		.watchdog_timer_enable(wd_en), .watchdog_timer_kick(wd_kick), .sw_reset_req(src[3]),
		.sw_reset_disable(sw_dis), .boost_active_req(boost_req), .boost_freq_sel(fsel),
		.auto_pulse_mode(auto_pm), .xtal_32k(xtal), .boost_below_level(below), .global_mode(gm),
		.res_clk_en(clk_en), .res_bias_en(bias_en), .cpu_en(cpu_en), .retain_hold(retain), .sys_reset(sys_rst),
		.reset_status(status), .powerup_monitor_en(mon_en), .main_internal_oscillator_en(osc_en),
		.boost_active(b_act), .boost_freq(b_freq), .boost_pulse(b_pulse));

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cmp_v(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cmp_n(input string nm, input int lo, input int hi, input int g);
		cmp_count++;
		if (g < lo || g > hi) begin
			miscompares++;
			$display("MISMATCH %s expected %0d to %0d seen %0d", nm, lo, hi, g);
		end
	endtask

	task automatic wait_for(input bit on_mode, input logic [1:0] v, input int lim, output int n);
		n = 0;
		while (n < lim && (on_mode ? gm !== v : sys_rst !== v[0])) begin
			tick(1);
			n++;
		end
		if (n >= lim) begin
			miscompares++;
			$display("MISMATCH wait for %h expected done seen timeout", v);
			final_report();
		end
	endtask

	task automatic trip(input int i, input logic [7:0] e);
		int n;
		src[i] = 1'b1;
		wait_for(1'b0, 2'h1, 20, n);
		cmp_v("reset_status", e, status);
		cmp_v("res_clk_en", 8'h00, clk_en);
		src[i] = 1'b0;
		wait_for(1'b0, 2'h0, 40, n);
	endtask

	task automatic set_mode(input logic [1:0] m);
		mode_req = m;
		mode_wr = 1'b1;
		tick(1);
		mode_wr = 1'b0;
		tick(1);
	endtask

	task automatic count_pulses(output int c);
		c = 0;
		repeat (160) begin
			tick(1);
			c += (b_pulse === 1'b1);
		end
	endtask

	initial begin
		int n;
		tick(3);
		rst = 1'b0;
		wait_for(1'b0, 2'h0, 20, n);
		cmp_v("global_mode", 8'h00, {6'h00, gm});
		cmp_v("res_clk_en", 8'h3d, clk_en);
		tmpl = 8'hc2;
		tick(2);
		cmp_v("res_clk_en", 8'hc3, clk_en);
		cmp_v("res_bias_en", 8'hc3, bias_en);
		trip(4, 8'h08);
		pwr_trip = 1'b1;
		ramp = 1'b1;
		tick(1);
		pwr_trip = 1'b0;
		tick(24);
		cmp_v("sys_reset", 8'h01, {7'h00, sys_rst});
		ramp = 1'b0;
		wait_for(1'b0, 2'h0, 20, n);
		cmp_v("reset_status", 8'h00, status);
		src[0] = 1'b1;
		tick(6);
		cmp_v("sys_reset", 8'h00, {7'h00, sys_rst});
		src[0] = 1'b0;
		vccd_ok = 1'b1;
		tick(6);
		cmp_v("powerup_monitor_en", 8'h00, {7'h00, mon_en});
		cmp_v("osc_en", 8'h01, {7'h00, osc_en});
		trip(0, 8'h02);
		trip(2, 8'h40);
		sw_dis = 1'b1;
		src[3] = 1'b1;
		src[1] = 1'b1;
		tick(6);
		cmp_v("sys_reset", 8'h00, {7'h00, sys_rst});
		src[3] = 1'b0;
		src[1] = 1'b0;
		sw_dis = 1'b0;
		trip(3, 8'h20);
		warn = 1'b1;
		tick(4);
		warn = 1'b0;
		cmp_v("reset_status", 8'h80, status);
		// The synchronised warning is still a wakeup for two edges, and a wakeup beats a self-off request.
		tick(2);
		cpu_off = 1'b1;
		tick(1);
		cpu_off = 1'b0;
		tick(2);
		cmp_v("res_clk_en", 8'hc2, clk_en);
		t_irq = 1'b1;
		tick(1);
		t_irq = 1'b0;
		tick(2);
		cmp_v("cpu_en", 8'h01, {7'h00, cpu_en});
		set_mode(2'h1);
		cmp_v("global_mode", 8'h01, {6'h00, gm});
		cmp_v("res_clk_en", 8'hc3, clk_en);
		set_mode(2'h2);
		cmp_v("global_mode", 8'h01, {6'h00, gm});
		wake_en = 4'h7;
		t_irq = 1'b1;
		tick(2);
		cmp_v("global_mode", 8'h01, {6'h00, gm});
		wake_en = 4'hf;
		tick(2);
		t_irq = 1'b0;
		cmp_v("global_mode", 8'h00, {6'h00, gm});
		cmp_v("cpu_en", 8'h01, {7'h00, cpu_en});
		for (int f = 0; f < 4; f++) begin
			fsel = 2'(f);
			tick(2);
			cmp_v("boost_freq", 8'(f), {6'h00, b_freq});
		end
		boost_req = 1'b0;
		tick(2);
		cmp_v("boost_active", 8'h00, {7'h00, b_act});
		set_mode(2'h2);
		cmp_v("sleep res_clk_en", 8'h00, clk_en);
		p_irq = 1'b1;
		wait_for(1'b1, 2'h0, 600, n);
		p_irq = 1'b0;
		cmp_n("sleep resume", 480, 490, n);
		set_mode(2'h2);
		trip(1, 8'h04);
		set_mode(2'h3);
		cmp_v("retain_hold", 8'h01, {7'h00, retain});
		cmp_v("boost_active", 8'h01, {7'h00, b_act});
		p_irq = 1'b1;
		tick(10);
		p_irq = 1'b0;
		cmp_v("global_mode", 8'h03, {6'h00, gm});
		pin_irq = 1'b1;
		wait_for(1'b1, 2'h0, 4100, n);
		pin_irq = 1'b0;
		cmp_n("hibernate resume", 10, 4006, n);
		xtal_run = 1'b1;
		auto_pm = 1'b1;
		below = 1'b1;
		tick(8);
		count_pulses(n);
		cmp_n("boost pulses", 19, 21, n);
		below = 1'b0;
		tick(4);
		count_pulses(n);
		cmp_n("boost pulses", 0, 0, n);
		rst = 1'b1;
		tick(3);
		cmp_v("boost_active", 8'h01, {7'h00, b_act});
		cmp_v("sys_reset", 8'h01, {7'h00, sys_rst});
		rst = 1'b0;
		wait_for(1'b0, 2'h0, 20, n);
		cmp_v("reset_status", 8'h00, status);
		cmp_v("global_mode", 8'h00, {6'h00, gm});
		wd_en = 1'b1;
		tick(1);
		wd_en = 1'b0;
		repeat (3) begin
			tick(12);
			wd_kick = 1'b1;
			tick(1);
			wd_kick = 1'b0;
		end
		cmp_v("sys_reset", 8'h00, {7'h00, sys_rst});
		wait_for(1'b0, 2'h1, 40, n);
		cmp_v("reset_status", 8'h10, status);
		final_report();
	end
endmodule
